/* acg_clock_gen.v */
// clock chain: source select, prescaler, sample clock, output rate and data-ready
//
// Functional notes
// RULE1 - master clock from crystal when external select is 0, direct input when 1
// RULE2 - in two-wire mode the serial clock pin is the master clock
// RULE3 - analog clock is master divided by 1, 2, 4 or 8 per prescale field
// RULE4 - analog portion runs from the prescaled analog clock enable
// RULE5 - sample clock is analog clock divided by four
// RULE6 - one modulator output refresh per sample clock period, per channel
// RULE7 - output rate is sample clock divided by ratio, marked by data-ready pulse
// RULE8 - ratio field decodes as 32 shifted left by field value, up to 4096
// RULE9 - sinc decimation notches at multiples of output rate, by frame alignment
// RULE10 - upper ratio pin captured on entry to two-wire mode and on watchdog reset; watchdog relatch here only in two-wire mode, unsettled strap refused
// RULE11 - data-ready low for half a sample period, unlatched, each output period
// RULE12 - ratio field resets to the encoding selecting 256
// RULE13 - all dividers are enable counters on master clock, cleared together
`include "acg_defs.vh"
`default_nettype none

module acg_clock_gen #(
	parameter RATIO_W = 3
) (
	// clock and reset (clk is the selected master clock)
	input  wire             clk,
	input  wire             nrst,
	// clock source control
	input  wire             external_clock_select,
	input  wire             two_wire_mode,
	output wire [1:0]       master_source,
	// configuration
	input  wire [1:0]       prescale_select,
	input  wire [RATIO_W-1:0] ratio_select_field,
	input  wire             ratio_select_load,
	// two-wire strap capture
	input  wire             upper_ratio_select_pin,
	input  wire             watchdog_reset,
	output reg              upper_ratio_latched_q,
	// clock enables and status
	output reg              analog_clock_en_q,
	output reg              digital_sample_clock_en_q,
	output reg              modulator_update_q,
	output reg              output_rate_clock_en_q,
	output reg  [RATIO_W-1:0] oversampling_ratio_q,
	output reg              data_ready_pin_n_q
);

	// ----------------------------------------
	// source select and strap synchroniser
	// ----------------------------------------
	// the mux itself lives in the pad ring; this reports which source is live
	assign master_source = two_wire_mode ? `ACG_SRC_SERIAL :            // [RULE2]
		(external_clock_select ? `ACG_SRC_DIRECT : `ACG_SRC_CRYSTAL);   // [RULE1]

	// index 0 is the strap pin, index 1 the interface mode pin
	wire [1:0] pin_raw;
	wire [1:0] pin_agree;
	wire [1:0] pin_level;
	reg        mode_sync_q;
	wire       mode_entry;
	wire       mode_stable;
	wire       strap_stable;
	wire       strap_event;

	assign pin_raw = {two_wire_mode, upper_ratio_select_pin};

	// three-stage sampling; change taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
			reg [2:0] stage_q;
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					stage_q <= 3'h0;
				end else begin
					stage_q <= {stage_q[1:0], pin_raw[gi]};
				end
			end
			// stage one may be metastable, so only stages two and three are read
			assign pin_agree[gi] = (stage_q[1] == stage_q[2]);
			assign pin_level[gi] = stage_q[2];
		end
	endgenerate

	assign mode_stable  = pin_agree[1];
	assign strap_stable = pin_agree[0];
	assign mode_entry   = mode_stable && pin_level[1] && !mode_sync_q;
	// watchdog relatch applies only once two-wire mode has settled in
	assign strap_event  = mode_entry || (watchdog_reset && mode_sync_q);

	// settled view of the interface mode, moved only when stages agree
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_sync_q <= 1'b0;
		end else if (mode_stable) begin
			mode_sync_q <= pin_level[1];
		end
	end

	// a strap still settling is refused rather than captured half-way
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			upper_ratio_latched_q <= 1'b0;
		end else if (strap_event && strap_stable) begin
			upper_ratio_latched_q <= pin_level[0];             // [RULE10]
		end
	end

	// ----------------------------------------
	// ratio register
	// ----------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			oversampling_ratio_q <= `ACG_RATIO_RESET;          // [RULE12]
		else if (ratio_select_load)
			oversampling_ratio_q <= ratio_select_field;
	end

	// ----------------------------------------
	// divider chain
	// ----------------------------------------
	function [3:0] pre_last;
		input [1:0] sel;
		begin
			case (sel)
				`ACG_PRE_DIV1: pre_last = 4'h0;
				`ACG_PRE_DIV2: pre_last = 4'h1;
				`ACG_PRE_DIV4: pre_last = 4'h3;
				`ACG_PRE_DIV8: pre_last = 4'h7;
				default:       pre_last = 4'h0;
			endcase
		end
	endfunction

	reg  [3:0]  pre_cnt_q;
	reg  [1:0]  quad_cnt_q;
	reg  [11:0] ratio_cnt_q;
	wire        pre_tick;
	wire        smp_tick;
	wire [11:0] ratio_last;
	wire [3:0]  ratio_log;
	wire        ratio_wrap;

	assign pre_tick   = (pre_cnt_q >= pre_last(prescale_select));           // [RULE3]
	assign smp_tick   = pre_tick && (quad_cnt_q == `ACG_QUAD_LAST);         // [RULE5]
	// last count is (1 << log) - 1; at 4096 the shift leaves twelve bits
	// and wraps to all ones, which is still the right last count
	assign ratio_log  = `ACG_RATIO_MIN_LOG + {1'b0, oversampling_ratio_q};
	assign ratio_last = (12'h001 << ratio_log) - 12'h001;                   // [RULE8]
	assign ratio_wrap = (ratio_cnt_q >= ratio_last);

	// counters share one reset so sample and result framing stay aligned
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre_cnt_q <= 4'h0;
		end else begin
			pre_cnt_q <= pre_tick ? 4'h0 : pre_cnt_q + 4'h1;                 // [RULE13]
		end
	end

	// four analog ticks make one sample period
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			quad_cnt_q <= 2'h0;
		end else if (pre_tick) begin
			quad_cnt_q <= quad_cnt_q + 2'h1;
		end
	end

	// a lowered ratio can leave the count past the end; >= wraps it at once
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ratio_cnt_q <= 12'h000;
		end else if (smp_tick) begin
			ratio_cnt_q <= ratio_wrap ? 12'h000 : ratio_cnt_q + 12'h001;    // [RULE7]
		end
	end

	// ----------------------------------------
	// enables and data-ready
	// ----------------------------------------
	// low-going pulse covers the first half of the sample period after each result
	wire [2:0] half_cnt;
	wire       ready_window;
	assign half_cnt     = {1'b0, quad_cnt_q};
	assign ready_window = (ratio_cnt_q == 12'h000) && (half_cnt < `ACG_HALF_SAMPLE);

	// analog portion is clocked by this enable, not by the master clock
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			analog_clock_en_q <= 1'b0;
		end else begin
			analog_clock_en_q <= pre_tick;                                    // [RULE4]
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			digital_sample_clock_en_q <= 1'b0;
		end else begin
			digital_sample_clock_en_q <= smp_tick;                            // [RULE5]
		end
	end

	// each sample period refreshes both modulator outputs exactly once
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			modulator_update_q <= 1'b0;
		end else begin
			modulator_update_q <= smp_tick;                                   // [RULE6]
		end
	end

	// result boundary: sinc frame ends on ratio wrap, notches follow rate
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			output_rate_clock_en_q <= 1'b0;
		end else begin
			output_rate_clock_en_q <= smp_tick && ratio_wrap;                 // [RULE9]
		end
	end

	// unlatched: the pin follows the window, nothing holds it low
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_ready_pin_n_q <= 1'b1;
		end else begin
			data_ready_pin_n_q <= !ready_window;                              // [RULE11]
		end
	end

endmodule

`default_nettype wire

/* acg_clock_gen_sva.sv */
// checker for the clock chain generator
`default_nettype none
module acg_clock_gen_sva #(parameter RATIO_W = 3) (
	input wire logic clk, nrst, external_clock_select, two_wire_mode, ratio_select_load,
	input wire logic [1:0] master_source, prescale_select,
	input wire logic [RATIO_W-1:0] ratio_select_field, oversampling_ratio_q,
	input wire logic analog_clock_en_q, digital_sample_clock_en_q, modulator_update_q,
	input wire logic output_rate_clock_en_q, data_ready_pin_n_q);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_mod_refresh: assert property (modulator_update_q == digital_sample_clock_en_q)
		else $error("modulator");
	a_sample_gap: assert property (digital_sample_clock_en_q |=> !digital_sample_clock_en_q[*3])
		else $error("sample gap");
	a_div_one: assert property ((prescale_select == 2'h0)[*3] ##0 analog_clock_en_q
		|=> analog_clock_en_q || prescale_select != 2'h0) else $error("div1");
	a_ratio_load: assert property (ratio_select_load |=> oversampling_ratio_q == $past(ratio_select_field))
		else $error("ratio load");
	a_ratio_hold: assert property (!ratio_select_load |=> $stable(oversampling_ratio_q))
		else $error("ratio hold");
	a_src_ext: assert property ((!two_wire_mode)[*4] |-> master_source == {1'b0, external_clock_select})
		else $error("source");
	a_src_two: assert property (two_wire_mode[*4] |-> master_source == 2'h2)
		else $error("two-wire source");
	a_ready_width: assert property ($fell(data_ready_pin_n_q) && prescale_select == 2'h0
		&& $past(prescale_select) == 2'h0
		|=> !data_ready_pin_n_q ##1 data_ready_pin_n_q) else $error("ready width");
	c_rate: cover property (output_rate_clock_en_q);
	c_ready: cover property ($fell(data_ready_pin_n_q));
	c_load: cover property (ratio_select_load);
endmodule
bind acg_clock_gen acg_clock_gen_sva #(.RATIO_W(RATIO_W)) i_acg_clock_gen_sva (.*);
`default_nettype wire

/* acg_defs.vh */
// constants for the converter clock-chain generator
`ifndef ACG_DEFS_VH
`define ACG_DEFS_VH

// ----------------------------------------
// prescale field encodings
// ----------------------------------------
`define ACG_PRE_DIV1      2'h0
`define ACG_PRE_DIV2      2'h1
`define ACG_PRE_DIV4      2'h2
`define ACG_PRE_DIV8      2'h3
`define ACG_PRE_RESET     2'h0

// ----------------------------------------
// ratio field and divider figures
// ----------------------------------------
`define ACG_RATIO_RESET   3'h3
`define ACG_RATIO_MIN_LOG 4'h5
`define ACG_SAMPLE_DIV    4'h4
`define ACG_QUAD_LAST     2'h3
`define ACG_HALF_SAMPLE   3'h2

// ----------------------------------------
// reported master clock source codes
// ----------------------------------------
`define ACG_SRC_CRYSTAL   2'h0
`define ACG_SRC_DIRECT    2'h1
`define ACG_SRC_SERIAL    2'h2

`endif

/* acg_host_model.sv */
// host side: counts data-ready pulses seen on the pin
`default_nettype none
module acg_host_model (input wire logic clk, input wire logic dr_n, output var int pulses);
	timeunit 1ns;
	timeprecision 100ps;
	logic last = 1'b1;
	initial pulses = 0;
	always @(posedge clk) begin
		if (last && !dr_n) pulses <= pulses + 1;
		last <= dr_n;
	end
endmodule
`default_nettype wire

/* test_acg_clock_gen.sv */
// self-checking bench for the clock chain generator
`default_nettype none
module test_acg_clock_gen;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
	$display("Error %s expected %0h seen %0h", n, e, s); end end
	logic clk = 0, nrst = 0, ext = 0, two = 0, load = 0, pin = 0, wdog = 0;
	logic ana, smp, mdu, rate, lat, dr_n;
	logic [1:0] pre = 0, src;
	logic [2:0] fld = 0, ratio;
	int failures = 0, checks_done = 0, pulses, gap = 0, low = 0, n;
	int exp_gap[$], exp_low[$];
	acg_clock_gen i_acg_clock_gen (.clk, .nrst, .external_clock_select(ext), .two_wire_mode(two),
		.master_source(src), .prescale_select(pre), .ratio_select_field(fld),
		.ratio_select_load(load), .upper_ratio_select_pin(pin), .watchdog_reset(wdog),
		.upper_ratio_latched_q(lat), .analog_clock_en_q(ana), .digital_sample_clock_en_q(smp),
		.modulator_update_q(mdu), .output_rate_clock_en_q(rate), .oversampling_ratio_q(ratio),
		.data_ready_pin_n_q(dr_n));
	acg_host_model i_acg_host_model (.clk, .dr_n, .pulses);
	initial forever #2.5 clk = ~clk;
	// monitor: gap between rate pulses and width of each low pulse
	always @(posedge clk) begin
		gap <= rate ? 1 : gap + 1;
		low <= dr_n ? 0 : low + 1;
		if (rate && exp_gap.size()) begin
			`CHK("rate gap", exp_gap[0], gap)
			exp_gap.delete(0);
		end
		if (dr_n && low > 0 && exp_low.size()) begin
			`CHK("ready width", exp_low[0], low)
			exp_low.delete(0);
		end
	end
	// two pulses pass first so a period cut by the change is not measured
	task automatic run(input logic [1:0] p, input logic [2:0] f);
		@(posedge clk) #1 pre = p;
		fld = f;
		load = 1;
		@(posedge clk) #1 load = 0;
		`CHK("ratio", f, ratio)
		n = pulses + 2;
		wait (pulses >= n);
		exp_gap.push_back(1 << (7 + p + f));
		exp_low.push_back(2 << p);
		wait (exp_gap.size() == 0 && exp_low.size() == 0);
	endtask
	task automatic results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(63028));
		repeat (20) @(posedge clk);
		#1 nrst = 1;
		`CHK("ratio reset", 3'h3, ratio)
		for (int p = 0; p < 4; p++) run(2'(p), {2'h0, p[0]});
		repeat (2) run(2'($urandom), 3'($urandom % 3));
		@(posedge clk) #1 ext = 1;
		@(posedge clk) #1 `CHK("source", 2'h1, src)
		two = 1;
		pin = 1;
		repeat (8) @(posedge clk);
		#1 `CHK("source", 2'h2, src)
		`CHK("strap", 1'b1, lat)
		pin = 0;
		repeat (8) @(posedge clk);
		#1 `CHK("strap hold", 1'b1, lat)
		wdog = 1;
		@(posedge clk) #1 wdog = 0;
		repeat (4) @(posedge clk);
		#1 `CHK("relatch", 1'b0, lat)
		results;
	end
	initial begin
		#450000 failures++;
		results;
	end
endmodule
`default_nettype wire
